/* sfs_pkg.sv */
// Behaviour
// - Abort request halts the running transfer at once and zeroes the shift counter.
// - Abort flag clears itself after the stop; other control bits stay unchanged.
// - Abort in transmit mode drives serial clock and serial data outputs high.
// - Abort leaves the shift register contents untouched.
// - On resume, data output keeps the pre-stop bit until the first new leading (falling) clock edge.
// - From reset until the program runs, all pins stay in initial state.
// - Clearing serial enable finishes the current word into the buffer, then stops.
package sfs_pkg;

  // Word sizes and transmit buffer depth
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] LEN_NIB = 4'h4;
  localparam logic [3:0] LEN_BYTE = 4'h8;

  // Internal serial clock half period in core cycles
  localparam logic [7:0] SCK_HALF = 8'h04;

  // Reset values
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] SHIFT_RST = 8'h00;

  typedef enum logic [1:0] {
    SFS_IDLE = 2'b00,
    SFS_RUN = 2'b01,
    SFS_STOP = 2'b10
  } sfs_state_t;

  // Software control levels
  typedef struct packed {
    logic serialEnable;
    logic txMode;
    logic extClock;
    logic wordLen8;
  } sfs_ctrl_t;

  // Pin group toward the peer
  typedef struct packed {
    logic sckOut;
    logic sckOe_n;
    logic soOut;
    logic soOe_n;
  } sfs_pins_t;

endpackage

/* sfs_sync.sv */
module sfs_sync
  import sfs_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sfs_sync_st_t;

  sfs_sync_st_t q_r;
  sfs_sync_st_t q_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    q_nxt.meta = async;
    q_nxt.stable = q_r.meta;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      q_r <= '1;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign synced = q_r.stable;

endmodule

/* sfs_fifo.sv */
module sfs_fifo
  import sfs_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 8
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } sfs_fifo_st_t;

  sfs_fifo_st_t q_r;
  sfs_fifo_st_t q_nxt;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count
  assign inReady = q_r.count < (AW + 1)'(D);
  assign outValid = q_r.count != '0;
  assign outData = q_r.mem[q_r.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    q_nxt = q_r;
    if (push)
    begin
      q_nxt.mem[q_r.wrPtr] = inData;
      q_nxt.wrPtr = (q_r.wrPtr == AW'(D - 1)) ? '0 : q_r.wrPtr + 1'b1;
    end
    if (pop)
    begin
      q_nxt.rdPtr = (q_r.rdPtr == AW'(D - 1)) ? '0 : q_r.rdPtr + 1'b1;
    end
    q_nxt.count = q_r.count + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

endmodule

/* sfs_serial.sv */
module sfs_serial
  import sfs_pkg::*;
#(
  parameter logic [7:0] SCK_HALF_CYC = SCK_HALF,
  parameter int TX_DEPTH = FIFO_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cpuRun,
  input wire sfs_ctrl_t ctrl,
  input wire logic transferAbortSet,
  output logic transferAbort,
  output logic busy,
  input wire logic [WORD_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [WORD_W-1:0] rxData,
  output logic rxValid,
  input wire logic sckIn,
  input wire logic siIn,
  output sfs_pins_t pins
);

  typedef struct packed {
    sfs_state_t state;
    logic [3:0] bitCnt;
    logic [WORD_W-1:0] shiftReg;
    logic [7:0] sckDiv;
    logic sckOut;
    logic sckPrev;
    logic soBit;
    logic heldBit;
    logic abort;
    logic [WORD_W-1:0] rxData;
    logic rxValid;
    logic [3:0] pinsOe_n;
  } sfs_st_t;

  sfs_st_t q_r;
  sfs_st_t q_nxt;
  logic [1:0] pinSync;
  logic [WORD_W-1:0] fifoData;
  logic fifoValid;
  logic fifoPop;
  logic sckFall;
  logic sckRise;
  logic startGo;
  logic wordDone;
  logic [3:0] wordLen;

  // Peer clock and data pass two flops before use
  sfs_sync #(
    .W(2)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async({sckIn, siIn}),
    .synced(pinSync)
  );

  // Transmit words queue here; a stalled link pushes back on the writer
  sfs_fifo #(
    .W(WORD_W),
    .D(TX_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .inData(txData),
    .inValid(txValid),
    .inReady(txReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  assign wordLen = ctrl.wordLen8 ? LEN_BYTE : LEN_NIB;

  // Serial clock edges, internal divider or sampled peer clock
  always_comb
  begin
    sckFall = 1'b0;
    sckRise = 1'b0;
    if (q_r.state == SFS_RUN)
    begin
      if (ctrl.extClock)
      begin
        sckFall = q_r.sckPrev && !pinSync[1];
        sckRise = !q_r.sckPrev && pinSync[1];
      end
      else if (q_r.sckDiv == 8'h00)
      begin
        sckFall = q_r.sckOut;
        sckRise = !q_r.sckOut;
      end
    end
  end

  // Start needs a word to send in transmit mode, nothing in receive mode
  assign startGo = (q_r.state == SFS_IDLE) && ctrl.serialEnable && cpuRun && !q_r.abort
    && !transferAbortSet && (!ctrl.txMode || fifoValid);
  assign wordDone = sckRise && (q_r.bitCnt == wordLen - 4'h1);
  assign fifoPop = (startGo || (wordDone && ctrl.serialEnable && !transferAbortSet))
    && ctrl.txMode && fifoValid;

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.rxValid = 1'b0;
    q_nxt.sckPrev = pinSync[1];
    // Pins stay released until the program is running
    q_nxt.pinsOe_n = cpuRun ? {ctrl.extClock, 1'b0, 2'b11} : 4'hF;
    if (q_r.state == SFS_RUN && !ctrl.extClock)
    begin
      q_nxt.sckDiv = (q_r.sckDiv == 8'h00) ? SCK_HALF_CYC - 8'h01 : q_r.sckDiv - 8'h01;
      if (q_r.sckDiv == 8'h00)
      begin
        q_nxt.sckOut = !q_r.sckOut;
      end
    end
    case (q_r.state)
      SFS_IDLE:
      begin
        if (startGo)
        begin
          q_nxt.state = SFS_RUN;
          q_nxt.bitCnt = CNT_RST;
          q_nxt.sckDiv = SCK_HALF_CYC - 8'h01;
          q_nxt.sckOut = IDLE_LEVEL;
          // Old bit reappears until the first new leading edge
          q_nxt.soBit = q_r.heldBit;
          if (ctrl.txMode)
          begin
            q_nxt.shiftReg = fifoData;
          end
        end
      end
      SFS_RUN:
      begin
        // Leading edge presents data, trailing edge samples
        if (sckFall && ctrl.txMode)
        begin
          q_nxt.soBit = q_r.shiftReg[0];
        end
        if (sckRise)
        begin
          q_nxt.shiftReg = q_r.shiftReg >> 1;
          q_nxt.shiftReg[wordLen[3] ? 3'h7 : 3'h3] = pinSync[0];
          q_nxt.bitCnt = q_r.bitCnt + 4'h1;
        end
        if (wordDone)
        begin
          q_nxt.bitCnt = CNT_RST;
          // Nibble words are shifted in at bit 3, so they end in the low half
          q_nxt.rxData = ctrl.wordLen8 ? q_nxt.shiftReg : {4'h0, q_nxt.shiftReg[3:0]};
          q_nxt.rxValid = 1'b1;
          // Enable low ends after this word completes
          if (!ctrl.serialEnable || (ctrl.txMode && !fifoValid))
          begin
            q_nxt.state = SFS_IDLE;
            q_nxt.sckOut = IDLE_LEVEL;
          end
          else if (ctrl.txMode)
          begin
            q_nxt.shiftReg = fifoData;
          end
        end
      end
      SFS_STOP:
      begin
        // Stop is done, so the flag drops itself
        q_nxt.abort = 1'b0;
        q_nxt.state = SFS_IDLE;
      end
      default:
      begin
        q_nxt.state = SFS_IDLE;
      end
    endcase
    // Forced stop overrides everything above; set beats self clear
    if (transferAbortSet)
    begin
      q_nxt.abort = 1'b1;
      q_nxt.state = SFS_STOP;
      q_nxt.bitCnt = CNT_RST;
      q_nxt.shiftReg = q_r.shiftReg;
      q_nxt.rxValid = 1'b0;
      q_nxt.heldBit = (q_r.state == SFS_RUN) ? q_r.soBit : q_r.heldBit;
      q_nxt.sckOut = IDLE_LEVEL;
      if (ctrl.txMode)
      begin
        q_nxt.soBit = IDLE_LEVEL;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      q_r.state <= SFS_IDLE;
      q_r.bitCnt <= CNT_RST;
      q_r.shiftReg <= SHIFT_RST;
      q_r.sckDiv <= 8'h00;
      q_r.sckOut <= IDLE_LEVEL;
      q_r.sckPrev <= IDLE_LEVEL;
      q_r.soBit <= IDLE_LEVEL;
      q_r.heldBit <= IDLE_LEVEL;
      q_r.abort <= 1'b0;
      q_r.rxData <= SHIFT_RST;
      q_r.rxValid <= 1'b0;
      q_r.pinsOe_n <= 4'hF;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from flops
  assign transferAbort = q_r.abort;
  assign busy = q_r.state == SFS_RUN;
  assign rxData = q_r.rxData;
  assign rxValid = q_r.rxValid;
  assign pins.sckOut = q_r.sckOut;
  assign pins.soOut = q_r.soBit;
  assign pins.sckOe_n = q_r.pinsOe_n[3];
  assign pins.soOe_n = q_r.pinsOe_n[2];

  property p_abortHalts;
    @(posedge sys_clk) disable iff (rst)
    transferAbortSet |=> (q_r.state == SFS_STOP) && (q_r.bitCnt == 4'h0) && !busy;
  endproperty
  a_abortHalts: assert property (p_abortHalts)
    else $error("abort did not halt the transfer");

  property p_abortSelfClear;
    @(posedge sys_clk) disable iff (rst)
    $rose(transferAbort) && !transferAbortSet |-> ##1 !transferAbort;
  endproperty
  a_abortSelfClear: assert property (p_abortSelfClear)
    else $error("abort flag did not clear after stop");

  property p_txIdleHigh;
    @(posedge sys_clk) disable iff (rst)
    transferAbortSet && ctrl.txMode |=> pins.sckOut && pins.soOut;
  endproperty
  a_txIdleHigh: assert property (p_txIdleHigh)
    else $error("clock or data not high after transmit abort");

  property p_shiftKept;
    @(posedge sys_clk) disable iff (rst)
    transferAbortSet |=> q_r.shiftReg == $past(q_r.shiftReg);
  endproperty
  a_shiftKept: assert property (p_shiftKept)
    else $error("abort changed the shift register");

  property p_resumeHeld;
    @(posedge sys_clk) disable iff (rst)
    startGo |=> pins.soOut == $past(q_r.heldBit);
  endproperty
  a_resumeHeld: assert property (p_resumeHeld)
    else $error("resume did not present the held bit");

  property p_resetRelease;
    @(posedge sys_clk) disable iff (rst)
    !cpuRun ##1 !cpuRun |-> pins.sckOe_n && pins.soOe_n && !busy;
  endproperty
  a_resetRelease: assert property (p_resetRelease)
    else $error("pins driven before program start");

  property p_gracefulEnd;
    @(posedge sys_clk) disable iff (rst)
    wordDone && !ctrl.serialEnable && !transferAbortSet |=> rxValid && !busy;
  endproperty
  a_gracefulEnd: assert property (p_gracefulEnd)
    else $error("word not finished on enable clear");

endmodule

/* sfs_peer.sv */
module sfs_peer
  import sfs_pkg::*;
(
  input wire logic extMode,
  input wire logic go,
  input wire logic frameClr,
  input wire sfs_pins_t pins,
  output logic sckIn,
  output logic siIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] txw;
  logic [7:0] rxw;
  int nBit = 0;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];

  // New word at bit 0; data changes on the falling clock edge
  task automatic fallEdge();
    if (nBit == 0)
    begin
      txw = 8'($urandom);
      txq.push_back(txw);
    end
    siIn = txw[nBit];
  endtask

  // Take data LSB first; after a frame the line shows the inverse, not the last bit
  task automatic riseEdge(input logic so);
    rxw[nBit] = so;
    nBit = nBit + 1;
    if (nBit == 8)
    begin
      rxq.push_back(rxw);
      nBit = 0;
      siIn = ~siIn;
    end
  endtask

  initial
  begin
    sckIn = 1'b1;
    siIn = 1'b1;
  end

  // Clocked by the device's own serial clock
  always @(negedge pins.sckOut) if (!extMode) fallEdge();
  always @(posedge pins.sckOut) if (!extMode) riseEdge(pins.soOut);
  // A stopped frame leaves a partial word behind
  always @(posedge frameClr) nBit = 0;

  // Peer clock: 800 ns period, only within a frame, idle high
  always @(posedge go)
  begin
    if (extMode)
    begin
      repeat (8)
      begin
        sckIn = 1'b0;
        fallEdge();
        #400;
        sckIn = 1'b1;
        #380;
        riseEdge(pins.soOut);
        #20;
      end
    end
  end
endmodule

/* serial_forced_stop_test.sv */
module serial_forced_stop_test
  import sfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst, cpuRun, abortSet, txValid, txReady, transferAbort, busy, rxValid;
  logic sckIn, siIn, peerGo, frameClr, held;
  logic [7:0] txData, rxData, d;
  sfs_ctrl_t ctrl;
  sfs_pins_t pins;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  logic [7:0] expq[$];

  sfs_serial dut (.sys_clk(sys_clk), .rst(rst), .cpuRun(cpuRun), .ctrl(ctrl),
    .transferAbortSet(abortSet), .transferAbort(transferAbort), .busy(busy),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
    .rxValid(rxValid), .sckIn(sckIn), .siIn(siIn), .pins(pins));
  sfs_peer peer (.extMode(ctrl.extClock), .go(peerGo), .frameClr(frameClr),
    .pins(pins), .sckIn(sckIn), .siIn(siIn));

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far above the roughly eight hundred cycles needed
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Valid stays up between words; caller drops it
  task automatic push(input logic [7:0] v);
    txData <= v;
    txValid <= 1'b1;
    do @(posedge sys_clk); while (txReady !== 1'b1);
  endtask

  // Bounded waits on design levels and pulses
  task automatic waitBusy(input logic lvl);
    n = 0;
    do @(posedge sys_clk); while (busy !== lvl && ++n < 300);
    chk1("busy", lvl, busy);
  endtask

  task automatic waitRx();
    n = 0;
    do @(posedge sys_clk); while (rxValid !== 1'b1 && ++n < 1000);
    chk1("rxValid", 1'b1, rxValid);
  endtask

  task automatic clrFrame();
    frameClr <= 1'b1;
    @(posedge sys_clk);
    frameClr <= 1'b0;
  endtask

  initial
  begin
    void'($urandom(32'h6DBF8426));
    rst = 1'b1;
    cpuRun = 1'b0;
    ctrl = sfs_ctrl_t'(4'h0);
    abortSet = 1'b0;
    txData = 8'h00;
    txValid = 1'b0;
    peerGo = 1'b0;
    frameClr = 1'b0;
    repeat (8) @(posedge sys_clk);
    chk8("pins", 8'h0F, {4'h0, pins});
    chk1("transferAbort", 1'b0, transferAbort);
    rst <= 1'b0;
    // Enabled but program not yet running: pins stay released
    ctrl <= sfs_ctrl_t'(4'h9);
    repeat (20) @(posedge sys_clk);
    chk1("busy", 1'b0, busy);
    chk8("pins", 8'h0F, {4'h0, pins});
    ctrl <= sfs_ctrl_t'(4'h0);
    cpuRun <= 1'b1;
    clrFrame();
    // Fill the buffer to refusal with corner and random words
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      expq.push_back(d);
      push(d);
    end
    txValid <= 1'b0;
    @(posedge sys_clk);
    chk1("txReady", 1'b0, txReady);
    ctrl <= sfs_ctrl_t'(4'hD);
    for (int k = 0; k < 8; k++)
    begin
      waitRx();
      chk8("rxData", peer.txq[k], rxData);
    end
    ctrl <= sfs_ctrl_t'(4'h0);
    waitBusy(1'b0);
    for (int k = 0; k < 8; k++) chk8("peerRx", expq[k], peer.rxq[k]);
    // Forced stop in mid-word
    clrFrame();
    push(8'($urandom));
    txValid <= 1'b0;
    ctrl <= sfs_ctrl_t'(4'hD);
    waitBusy(1'b1);
    repeat (9 + $urandom_range(0, 20)) @(posedge sys_clk);
    abortSet <= 1'b1;
    @(posedge sys_clk);
    held = pins.soOut;
    abortSet <= 1'b0;
    @(posedge sys_clk);
    chk1("transferAbort", 1'b1, transferAbort);
    chk1("busy", 1'b0, busy);
    chk1("sckOut", 1'b1, pins.sckOut);
    chk1("soOut", 1'b1, pins.soOut);
    @(posedge sys_clk);
    chk1("transferAbort", 1'b0, transferAbort);
    clrFrame();
    push(8'($urandom));
    txValid <= 1'b0;
    waitBusy(1'b1);
    chk1("soOut", held, pins.soOut);
    // Enable low, mode kept, so the resumed byte ends cleanly
    ctrl <= sfs_ctrl_t'(4'h5);
    waitBusy(1'b0);
    // Four-bit word: low nibble out, low nibble in
    clrFrame();
    d = 8'($urandom);
    push(d);
    txValid <= 1'b0;
    ctrl <= sfs_ctrl_t'(4'hC);
    waitRx();
    chk8("rxNibble", {4'h0, peer.txq[peer.txq.size() - 1][3:0]}, rxData);
    chk8("peerNibble", {4'h0, d[3:0]}, {4'h0, peer.rxw[3:0]});
    ctrl <= sfs_ctrl_t'(4'h4);
    waitBusy(1'b0);
    // Receive on the peer's clock
    clrFrame();
    ctrl <= sfs_ctrl_t'(4'hB);
    repeat (4) @(posedge sys_clk);
    chk1("sckOe_n", 1'b1, pins.sckOe_n);
    peerGo <= 1'b1;
    // Enable drops mid-frame; the peer's clock still finishes the word
    repeat (20) @(posedge sys_clk);
    ctrl <= sfs_ctrl_t'(4'h3);
    waitRx();
    chk8("rxData", peer.txq[peer.txq.size() - 1], rxData);
    peerGo <= 1'b0;
    waitBusy(1'b0);
    finish_test();
  end
endmodule
